/* File: shared/mem_map_defs.vh */
// memory map constants for the data space decoder
`ifndef MEM_MAP_DEFS_VH
`define MEM_MAP_DEFS_VH
`define BANK_LO        8'h00
`define BANK_HI        8'h3F
`define WIN_LO         8'h40
`define WIN_HI         8'h7F
`define IDX_X          8'h80
`define IDX_Y          8'h81
`define SHORT_V        8'h82
`define SHORT_W        8'h83
`define RAM_LO         8'h84
`define RAM_HI         8'hBF
`define PORT_DATA_LO   8'hC0
`define PORT_DATA_HI   8'hC2
`define PORT_DIR_LO    8'hC4
`define PORT_DIR_HI    8'hC6
`define WIN_BASE_ADDR  8'hC9
`define PORT_OPT_LO    8'hCC
`define PORT_OPT_HI    8'hCE
`define ADC_DATA       8'hD0
`define ADC_CTRL       8'hD1
`define TMR_PSC        8'hD2
`define TMR_CNT        8'hD3
`define TMR_SCR        8'hD4
`define BANK_SEL_ADDR  8'hE8
`define ACC_ADDR       8'hFF
`define WIN_OFS_W      6
`define WIN_BASE_W     6
`define PC_W           12
`define STACK_DEPTH    6
`define STACK_PTR_W    3
`define VEC_IRQ_LO     12'hFF0
`define VEC_IRQ_HI     12'hFF7
`define VEC_NMI_LO     12'hFFC
`define VEC_NMI_HI     12'hFFD
`define VEC_RST_LO     12'hFFE
`define USER_LO        12'h080
`define USER_HI        12'hF9F
`define BSEL_RAM2      4
`define BSEL_EE1       1
`define BSEL_EE0       0
`define RD_UNDEF       8'hFF
`endif

/* File: hw/return_stack.v */
// six-entry return address stack
`timescale 1ns/1ps
`include "mem_map_defs.vh"
module return_stack (
	// clock and reset
	input  wire                  clk,
	input  wire                  rst_n,
	// push and pop
	input  wire                  push,
	input  wire                  pop,
	input  wire [`PC_W-1:0]      push_addr,
	output reg  [`PC_W-1:0]      top_addr,
	output reg                   empty
);
	reg [`PC_W-1:0]        entry [0:`STACK_DEPTH-1];
	reg [`STACK_PTR_W-1:0] depth;
	integer i;
	// overflow drops the oldest entry, as a fixed-depth stack does
	always @(posedge clk) begin
		if (!rst_n) begin
			depth    <= {`STACK_PTR_W{1'b0}};
			top_addr <= {`PC_W{1'b0}};
			empty    <= 1'b1;
			for (i = 0; i < `STACK_DEPTH; i = i + 1)
				entry[i] <= {`PC_W{1'b0}};
		end else if (push) begin
			for (i = `STACK_DEPTH-1; i > 0; i = i - 1)
				entry[i] <= entry[i-1];
			entry[0] <= push_addr;
			top_addr <= push_addr;
			empty    <= 1'b0;
			if (depth != `STACK_DEPTH)
				depth <= depth + 3'h1;
		end else if (pop && depth != {`STACK_PTR_W{1'b0}}) begin
			for (i = 0; i < `STACK_DEPTH-1; i = i + 1)
				entry[i] <= entry[i+1];
			entry[`STACK_DEPTH-1] <= {`PC_W{1'b0}};
			top_addr <= entry[1];
			empty    <= (depth == 3'h1);
			depth    <= depth - 3'h1;
		end
	end
endmodule

/* File: hw/data_space_decode.v */
// data and program space decoder with movable read-only data window
`timescale 1ns/1ps
`include "mem_map_defs.vh"
// Operation
// - data reads at 40h-7Fh go to program memory through the window
// - window address is base bits above the six low data address bits
// - one step of the base moves the window by 64 bytes
// - window reaches every program location 000h to FFFh
// - base register at C9h is write only; no reads or bit operations
// - base register is not reset; software writes it before use
// - only the low six base bits are kept; top two ignored
// - program space uses a 12-bit counter, 4096 locations
// - six-entry 12-bit return stack for calls and interrupts
// - decode interrupt, nmi and reset vectors and user code area
// - decode index, short-direct, general ram and accumulator slots
// - data 00h-3Fh is the banked ram/eeprom page area
// - bank select at E8h: bit4 ram page 2, bits 1/0 eeprom pages
// - port data, direction and option registers get their slots
// - converter and timer registers get their slots
// - readout protection blocks external program memory reads
module data_space_decode (
	// clock and reset
	input  wire                  clk,
	input  wire                  rst_n,
	// core data access, same clock
	input  wire [7:0]            data_addr,
	input  wire                  data_rd,
	input  wire                  data_wr,
	input  wire [7:0]            data_wdata,
	output reg  [7:0]            data_rdata,
	output reg                   data_rvalid,
	// core fetch and stack
	input  wire [`PC_W-1:0]      pc,
	input  wire                  call_push,
	input  wire                  ret_pop,
	output reg  [`PC_W-1:0]      ret_addr,
	output reg                   stack_empty,
	output reg                   pc_is_irq_vec,
	output reg                   pc_is_nmi_vec,
	output reg                   pc_is_rst_vec,
	output reg                   pc_is_user,
	// program memory port
	output reg  [`PC_W-1:0]      prog_addr,
	output reg                   prog_rd,
	input  wire [7:0]            prog_rdata,
	// external readout of program memory
	input  wire                  readout_protect,
	input  wire                  ext_rd,
	input  wire [`PC_W-1:0]      ext_addr,
	output reg  [7:0]            ext_rdata,
	output reg                   ext_rvalid,
	// data space selects, one cycle after the access
	output reg                   sel_bank,
	output reg  [2:0]            bank_page,
	output reg                   sel_index,
	output reg                   sel_short,
	output reg                   sel_ram,
	output reg                   sel_acc,
	output reg                   sel_port_data,
	output reg                   sel_port_dir,
	output reg                   sel_port_opt,
	output reg                   sel_adc,
	output reg                   sel_timer,
	output reg  [7:0]            sel_addr,
	output reg                   sel_rd,
	output reg                   sel_wr,
	output reg  [7:0]            sel_wdata,
	input  wire [7:0]            periph_rdata
);
	reg [`WIN_BASE_W-1:0] rom_window_base;
	reg [7:0]             data_bank_select;
	reg                   win_pend;
	reg                   per_pend;
	reg                   ext_pend;
	reg                   prot_pend;
	wire [`PC_W-1:0]      stk_top;
	wire                  stk_empty;

	wire in_bank  = (data_addr <= `BANK_HI);
	wire in_win   = (data_addr >= `WIN_LO) && (data_addr <= `WIN_HI);
	wire in_index = (data_addr == `IDX_X) || (data_addr == `IDX_Y);
	wire in_short = (data_addr == `SHORT_V) || (data_addr == `SHORT_W);
	wire in_ram   = (data_addr >= `RAM_LO) && (data_addr <= `RAM_HI);
	wire in_acc   = (data_addr == `ACC_ADDR);
	wire in_pdat  = (data_addr >= `PORT_DATA_LO) && (data_addr <= `PORT_DATA_HI);
	wire in_pdir  = (data_addr >= `PORT_DIR_LO) && (data_addr <= `PORT_DIR_HI);
	wire in_popt  = (data_addr >= `PORT_OPT_LO) && (data_addr <= `PORT_OPT_HI);
	wire in_adc   = (data_addr == `ADC_DATA) || (data_addr == `ADC_CTRL);
	wire in_tmr   = (data_addr >= `TMR_PSC) && (data_addr <= `TMR_SCR);
	wire in_per   = in_bank | in_index | in_short | in_ram | in_acc
	              | in_pdat | in_pdir | in_popt | in_adc | in_tmr;

	// window address: base on top, low data address bits below
	wire [`PC_W-1:0] win_addr = {rom_window_base, data_addr[`WIN_OFS_W-1:0]};

	// two pages at once would clash on the bus, so a multi-bit code enables none
	wire [2:0]       page_bits = {data_bank_select[`BSEL_RAM2], data_bank_select[`BSEL_EE1],
	                              data_bank_select[`BSEL_EE0]};
	wire             page_one  = (page_bits == 3'h1) || (page_bits == 3'h2)
	                           || (page_bits == 3'h4);

	// no reset: contents stay undefined until software writes them
	always @(posedge clk) begin
		if (data_wr && data_addr == `WIN_BASE_ADDR)
			rom_window_base <= data_wdata[`WIN_BASE_W-1:0];
		if (data_wr && data_addr == `BANK_SEL_ADDR)
			data_bank_select <= data_wdata;
	end

	always @(posedge clk) begin
		if (!rst_n) begin
			prog_addr     <= {`PC_W{1'b0}};
			prog_rd       <= 1'b0;
			win_pend      <= 1'b0;
			per_pend      <= 1'b0;
			ext_pend      <= 1'b0;
			prot_pend     <= 1'b0;
			data_rdata    <= 8'h00;
			data_rvalid   <= 1'b0;
			ext_rdata     <= 8'h00;
			ext_rvalid    <= 1'b0;
			sel_bank      <= 1'b0;
			bank_page     <= 3'h0;
			sel_index     <= 1'b0;
			sel_short     <= 1'b0;
			sel_ram       <= 1'b0;
			sel_acc       <= 1'b0;
			sel_port_data <= 1'b0;
			sel_port_dir  <= 1'b0;
			sel_port_opt  <= 1'b0;
			sel_adc       <= 1'b0;
			sel_timer     <= 1'b0;
			sel_addr      <= 8'h00;
			sel_rd        <= 1'b0;
			sel_wr        <= 1'b0;
			sel_wdata     <= 8'h00;
			pc_is_irq_vec <= 1'b0;
			pc_is_nmi_vec <= 1'b0;
			pc_is_rst_vec <= 1'b0;
			pc_is_user    <= 1'b0;
			ret_addr      <= {`PC_W{1'b0}};
			stack_empty   <= 1'b1;
		end else begin
			// core window read has the memory port over external readout
			if (data_rd && in_win) begin
				prog_addr <= win_addr;
				prog_rd   <= 1'b1;
			end else if (ext_rd && !readout_protect) begin
				prog_addr <= ext_addr;
				prog_rd   <= 1'b1;
			end else begin
				prog_rd <= 1'b0;
			end
			win_pend  <= data_rd && in_win;
			per_pend  <= data_rd && !in_win;
			ext_pend  <= ext_rd && !readout_protect && !(data_rd && in_win);
			prot_pend <= ext_rd && readout_protect;
			// second cycle: return the read data
			data_rvalid <= win_pend | per_pend;
			if (win_pend)
				data_rdata <= prog_rdata;
			else if (per_pend)
				data_rdata <= periph_rdata;
			// protected readout answers with a blank value, never memory
			ext_rvalid <= ext_pend | prot_pend;
			if (ext_pend)
				ext_rdata <= prog_rdata;
			else if (prot_pend)
				ext_rdata <= `RD_UNDEF;
			// peripheral and ram selects; reserved and write-only slots raise none
			sel_bank      <= in_bank;
			bank_page     <= page_one ? page_bits : 3'h0;
			sel_index     <= in_index;
			sel_short     <= in_short;
			sel_ram       <= in_ram;
			sel_acc       <= in_acc;
			sel_port_data <= in_pdat;
			sel_port_dir  <= in_pdir;
			sel_port_opt  <= in_popt;
			sel_adc       <= in_adc;
			sel_timer     <= in_tmr;
			sel_addr      <= data_addr;
			sel_rd        <= data_rd && in_per;
			sel_wr        <= data_wr && in_per;
			sel_wdata     <= data_wdata;
			// program space decode of the fetch address
			pc_is_irq_vec <= (pc >= `VEC_IRQ_LO) && (pc <= `VEC_IRQ_HI);
			pc_is_nmi_vec <= (pc >= `VEC_NMI_LO) && (pc <= `VEC_NMI_HI);
			pc_is_rst_vec <= (pc >= `VEC_RST_LO);
			pc_is_user    <= (pc >= `USER_LO) && (pc <= `USER_HI);
			ret_addr      <= stk_top;
			stack_empty   <= stk_empty;
		end
	end

	return_stack u_stack (
		.clk       (clk),
		.rst_n     (rst_n),
		.push      (call_push),
		.pop       (ret_pop),
		.push_addr (pc),
		.top_addr  (stk_top),
		.empty     (stk_empty)
	);
endmodule

/* File: tb/data_space_decode_assertions.sv */
// port assertions for the data space decoder
`timescale 1ns/1ps
module data_space_decode_chk (
	// clock and reset
	input wire		clk,
	input wire		rst_n,
	// watched ports
	input wire [7:0]	data_addr,
	input wire		data_rd,
	input wire		data_wr,
	input wire [7:0]	data_wdata,
	input wire		data_rvalid,
	input wire [11:0]	pc,
	input wire		pc_is_rst_vec,
	input wire [11:0]	prog_addr,
	input wire		prog_rd,
	input wire		readout_protect,
	input wire		ext_rd,
	input wire [7:0]	ext_rdata,
	input wire		ext_rvalid,
	input wire		sel_bank,
	input wire		sel_ram,
	input wire		sel_rd,
	input wire		sel_wr,
	input wire [7:0]	sel_wdata
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire win = data_rd && data_addr[7:6] == 2'b01;
	property p_win_addr; win |=> prog_rd && prog_addr[5:0] == $past(data_addr[5:0]); endproperty
	a_win_addr: assert property (p_win_addr) else $error("window address wrong");
	property p_win_valid; data_rd |-> ##2 data_rvalid; endproperty
	a_win_valid: assert property (p_win_valid) else $error("read not answered");
	property p_no_prog; data_rd && data_addr[7:6] != 2'b01 && !ext_rd |=> !prog_rd; endproperty
	a_no_prog: assert property (p_no_prog) else $error("stray program read");
	property p_rst_vec; $past(rst_n) |-> pc_is_rst_vec == ($past(pc) >= 12'hFFE); endproperty
	a_rst_vec: assert property (p_rst_vec) else $error("reset vector decode");
	property p_ram; $past(rst_n) |-> sel_ram == ($past(data_addr) inside {[8'h84:8'hBF]}); endproperty
	a_ram: assert property (p_ram) else $error("ram decode");
	property p_bank; $past(rst_n) |-> sel_bank == ($past(data_addr) < 8'h40); endproperty
	a_bank: assert property (p_bank) else $error("bank decode");
	property p_prot; ext_rd && readout_protect && !win |-> ##2 ext_rvalid && ext_rdata == 8'hFF;
	endproperty
	a_prot: assert property (p_prot) else $error("protected readout leaked");
	property p_wo; data_rd && (data_addr == 8'hC9 || data_addr == 8'hE8) |=> !sel_rd; endproperty
	a_wo: assert property (p_wo) else $error("write only register read");
	property p_wr; data_wr && data_addr inside {[8'h84:8'hBF]} |=> sel_wr && sel_ram &&
		sel_wdata == $past(data_wdata); endproperty
	a_wr: assert property (p_wr) else $error("ram write not passed on");
	property p_rsv_wr; data_wr && data_addr inside {8'hC9, 8'hCA, 8'hE8} |=> !sel_wr;
	endproperty
	a_rsv_wr: assert property (p_rsv_wr) else $error("reserved write reached a slot");
	property p_ext_drop; ext_rd && !readout_protect && win |-> ##2 !ext_rvalid; endproperty
	a_ext_drop: assert property (p_ext_drop) else $error("external read beat the core");
	c_drop: cover property (ext_rd && !readout_protect && win);
	c_win: cover property (win ##2 data_rvalid);
	c_prot: cover property (ext_rvalid && readout_protect);
	c_rst: cover property (pc_is_rst_vec);
endmodule
bind data_space_decode data_space_decode_chk u_chk (.clk, .rst_n, .data_addr, .data_rd,
	.data_wr, .data_wdata, .data_rvalid, .pc, .pc_is_rst_vec, .prog_addr, .prog_rd,
	.readout_protect, .ext_rd, .ext_rdata, .ext_rvalid, .sel_bank, .sel_ram, .sel_rd, .sel_wr,
	.sel_wdata);

/* File: tb/mem_model.sv */
// program memory and peripheral model on the decoder's far side
`timescale 1ns/1ps
module mem_model (
	// clock
	input wire		clk,
	// program memory
	input wire [11:0]	prog_addr,
	input wire		prog_rd,
	output reg [7:0]	prog_rdata,
	// peripherals
	input wire [7:0]	sel_addr,
	input wire		sel_rd,
	output reg [7:0]	periph_rdata
);
	reg [11:0]	pa_q = 12'h000;
	reg [7:0]	sa_q = 8'h00;
	reg		pr_q = 1'b0;
	reg		sr_q = 1'b0;
	reg [7:0]	junk = 8'hA5;
	function [7:0] rom(input [11:0] a);
		rom = a[7:0] ^ {a[11:8], a[11:8]};
	endfunction
	always @(posedge clk) begin
		pa_q <= prog_addr;
		sa_q <= sel_addr;
		pr_q <= prog_rd;
		sr_q <= sel_rd;
		junk <= junk + 8'h3B;
	end
	// data held for the request cycle and the next; otherwise a moving pattern
	always @* begin
		prog_rdata = prog_rd ? rom(prog_addr) : (pr_q ? rom(pa_q) : junk);
		periph_rdata = sel_rd ? ~sel_addr : (sr_q ? ~sa_q : ~junk);
	end
endmodule

/* File: tb/data_space_decode_tb.sv */
// self-checking bench for the data space decoder
`timescale 1ns/1ps
module data_space_decode_tb;
	localparam [95:0] SA = {8'h00, 8'h80, 8'h83, 8'h84, 8'hBF, 8'hFF, 8'hC2, 8'hC4, 8'hCE,
		8'hD1, 8'hD4, 8'hC3};
	localparam [119:0] SE = {10'h200, 10'h100, 10'h080, 10'h040, 10'h040, 10'h020, 10'h010,
		10'h008, 10'h004, 10'h002, 10'h001, 10'h000};
	localparam [119:0] PV = {12'hFF0, 12'hFF7, 12'hFF8, 12'hFFC, 12'hFFD, 12'hFFE, 12'hF9F,
		12'hFA0, 12'h07F, 12'h080};
	localparam [39:0] PE = {4'h8, 4'h8, 4'h0, 4'h4, 4'h4, 4'h2, 4'h1, 4'h0, 4'h0, 4'h1};
	reg clk = 0, rst_n = 0, data_rd = 0, data_wr = 0, call_push = 0, ret_pop = 0;
	reg readout_protect = 0, ext_rd = 0;
	reg [7:0] data_addr = 8'h00, data_wdata = 8'h00, b;
	reg [11:0] pc = 12'h000, ext_addr = 12'hABC, d;
	wire [7:0] data_rdata, ext_rdata, prog_rdata, periph_rdata, sel_addr;
	wire [11:0] ret_addr, prog_addr;
	wire [2:0] bank_page;
	wire [9:0] sels;
	wire data_rvalid, stack_empty, pc_is_user, prog_rd, ext_rvalid, sel_rd;
	wire pc_is_irq_vec, pc_is_nmi_vec, pc_is_rst_vec;
	integer error_cnt = 0, n_compared = 0, i, n;
	always #10 clk = ~clk;
	data_space_decode uut (.clk, .rst_n, .data_addr, .data_rd, .data_wr, .data_wdata,
		.data_rdata, .data_rvalid, .pc, .call_push, .ret_pop, .ret_addr, .stack_empty,
		.pc_is_irq_vec, .pc_is_nmi_vec, .pc_is_rst_vec, .pc_is_user, .prog_addr,
		.prog_rd, .prog_rdata, .readout_protect, .ext_rd, .ext_addr, .ext_rdata, .ext_rvalid,
		.sel_bank(sels[9]), .bank_page, .sel_index(sels[8]), .sel_short(sels[7]),
		.sel_ram(sels[6]), .sel_acc(sels[5]), .sel_port_data(sels[4]), .sel_port_dir(sels[3]),
		.sel_port_opt(sels[2]), .sel_adc(sels[1]), .sel_timer(sels[0]), .sel_addr, .sel_rd,
		.sel_wr(), .sel_wdata(), .periph_rdata);
	mem_model pm (.clk, .prog_addr, .prog_rd, .prog_rdata, .sel_addr, .sel_rd, .periph_rdata);
	task tick; begin
		@(posedge clk);
		#1;
	end endtask
	task tally_and_finish; begin
		$display("compared %0d, errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	end endtask
	task chk(input [11:0] got, input [11:0] exp); begin
		n_compared = n_compared + 1;
		if (got !== exp) begin
			error_cnt = error_cnt + 1;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	end endtask
	task wr(input [7:0] a, input [7:0] v); begin
		data_addr = a;
		data_wdata = v;
		data_wr = 1;
		tick;
		data_wr = 0;
		tick;
	end endtask
	// the answer pulse lasts one cycle, so it is polled after every edge
	task rd(input [7:0] a); begin
		data_addr = a;
		data_rd = 1;
		tick;
		data_rd = 0;
		for (n = 0; n < 4 && data_rvalid !== 1'b1; n = n + 1) tick;
		d = {4'h0, data_rdata};
		if (n == 4) begin
			error_cnt = error_cnt + 1;
			tally_and_finish;
		end
	end endtask
	initial begin
		repeat (6) @(posedge clk);
		#1 rst_n = 1;
		chk(stack_empty, 1);
		for (i = 0; i < 3; i = i + 1) begin
			b = (i == 0) ? 8'hC0 : (i == 1) ? 8'h01 : 8'hFF;
			wr(8'h90, b);
			wr(8'hC9, b);
			wr(8'hCA, 8'h00);
			rd(8'hC9);
			rd(8'h40);
			chk(d, {4'h0, pm.rom({b[5:0], 6'h00})});
			rd(8'h7F);
			chk(d, {4'h0, pm.rom({b[5:0], 6'h3F})});
		end
		for (i = 0; i < 3; i = i + 1) begin
			wr(8'hE8, (i == 2) ? 8'h10 : 8'h01 << i);
			tick;
			chk(bank_page, 3'h1 << i);
		end
		wr(8'hE8, 8'h03);
		tick;
		chk(bank_page, 12'h000);
		rd(8'hE8);
		for (i = 0; i < 12; i = i + 1) begin
			data_addr = SA[8*i +: 8];
			pc = {4'hF, SA[8*i +: 8]};
			tick;
			chk(sels, SE[10*i +: 10]);
		end
		for (i = 0; i < 10; i = i + 1) begin
			pc = PV[12*i +: 12];
			tick;
			chk({pc_is_irq_vec, pc_is_nmi_vec, pc_is_rst_vec, pc_is_user}, PE[4*i +: 4]);
		end
		rd(8'hD0);
		chk(d, 12'h02F);
		pc = 12'h123;
		call_push = 1;
		tick;
		pc = 12'h456;
		tick;
		call_push = 0;
		repeat (2) tick;
		chk(ret_addr, 12'h456);
		for (i = 0; i < 2; i = i + 1) begin
			ret_pop = 1;
			tick;
			ret_pop = 0;
			repeat (2) tick;
			chk(i ? stack_empty : ret_addr, i ? 12'h001 : 12'h123);
		end
		// seven pushes overflow the six entries; the fifth pop must leave 101 on top, seven pops empty
		call_push = 1;
		for (i = 0; i < 7; i = i + 1) begin
			pc = 12'h100 + i[11:0];
			tick;
		end
		call_push = 0;
		for (i = 0; i < 7; i = i + 1) begin
			ret_pop = 1;
			tick;
			ret_pop = 0;
			repeat (2) tick;
			if (i == 4) chk(ret_addr, 12'h101);
		end
		chk(stack_empty, 12'h001);
		for (i = 0; i < 2; i = i + 1) begin
			readout_protect = i[0];
			ext_rd = 1;
			tick;
			ext_rd = 0;
			for (n = 0; n < 4 && ext_rvalid !== 1'b1; n = n + 1) tick;
			chk({4'h0, ext_rdata}, i ? 12'h0FF : {4'h0, pm.rom(ext_addr)});
			if (n == 4) begin
				error_cnt = error_cnt + 1;
				tally_and_finish;
			end
		end
		// external read in the same cycle as a window read is dropped
		readout_protect = 0;
		ext_rd = 1;
		data_addr = 8'h41;
		data_rd = 1;
		tick;
		ext_rd = 0;
		data_rd = 0;
		tick;
		chk({2'b00, data_rvalid, ext_rvalid, data_rdata}, {4'h2, pm.rom(12'hFC1)});
		tally_and_finish;
	end
endmodule
